/* File: fbp_pkg.sv */
// Shared constants and types for the butterfly pipeline
package fbp_pkg;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned SLICE_W = 8;
  localparam int unsigned PROD_W = 32;
  localparam int unsigned SEQ_LEN = 10;
  localparam int unsigned INIT_INTERVAL = 4;
  localparam int unsigned TAG_W = 2;
  localparam int unsigned STEP_W = 4;
  localparam int unsigned TW_ADDR_W = 8;
  // Control step numbers (0 based) of the ten-step sequence
  localparam logic [3:0] STEP_READ_B = 4'h0;
  localparam logic [3:0] STEP_READ_A = 4'h2;
  localparam logic [3:0] STEP_MUL_RR = 4'h1;
  localparam logic [3:0] STEP_MUL_RI = 4'h2;
  localparam logic [3:0] STEP_MUL_IR = 4'h3;
  localparam logic [3:0] STEP_MUL_II = 4'h4;
  localparam logic [3:0] STEP_COMMON = 4'h5;
  localparam logic [3:0] STEP_WRITE_B = 4'h7;
  localparam logic [3:0] STEP_WRITE_A = 4'h9;
  localparam logic [1:0] SLOT_RESET = 2'h0;
  // Twiddle source select
  typedef enum logic [0:0] {
    FBP_TW_ROM = 1'b0,
    FBP_TW_GEN = 1'b1
  } fbp_tw_src_type;
  // Sequencer phase states
  typedef enum logic [1:0] {
    FBP_PH_0 = 2'b00,
    FBP_PH_1 = 2'b01,
    FBP_PH_2 = 2'b10,
    FBP_PH_3 = 2'b11
  } fbp_phase_type;
endpackage : fbp_pkg

/* File: fbp_slice_alu.sv */
// Cascadable 8-bit add/subtract slice
`timescale 1ns/100ps
module fbp_slice_alu #(
  parameter int unsigned W = 8
) (
  // Operands
  input wire logic [W-1:0] a_in,
  input wire logic [W-1:0] b_in,
  input wire logic sub_in,
  input wire logic carry_in,
  // Result
  output logic [W-1:0] sum_out,
  output logic carry_out
);
  logic [W:0] total;

  // Subtract by adding the inverted operand
  always_comb begin
    total = {1'b0, a_in} + {1'b0, (sub_in ? ~b_in : b_in)} + {{W{1'b0}}, carry_in};
    sum_out = total[W-1:0];
    carry_out = total[W];
  end
endmodule : fbp_slice_alu

/* File: fbp_butterfly.sv */
// Pipelined radix-2 butterfly datapath with a shared multiplier
// Behaviour
// - Each processor is two cascaded 8-bit slices
// - One shared multiplier, data from operand port
// - Twiddle operand from ROM or generator
// - Only upper product half returns to processors
// - One butterfly spans ten control steps
// - New butterfly starts every four cycles
// - Steps overlap four apart, three in flight
// - Each memory write tagged with its butterfly; reads untagged
// - Outputs A plus product, A minus product
// - Real term BrWr-BiWi, reused for both
// - Imag term BiWr+BrWi, reused for both
// - Four products, three adds, three subtracts
// - Common term computed once per butterfly
`timescale 1ns/100ps
module fbp_butterfly
  import fbp_pkg::*;
#(
  parameter int unsigned DW = DATA_W,
  parameter int unsigned AW = TW_ADDR_W
) (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire logic clk_en_in,
  // Control
  input wire logic start_in,
  input wire logic tw_src_in,
  input wire logic [AW-1:0] tw_index_in,
  // Memory read data (same clock domain)
  input wire logic [DW-1:0] mem_rd_re_in,
  input wire logic [DW-1:0] mem_rd_im_in,
  // Twiddle ROM and generator data
  input wire logic [DW-1:0] rom_wr_in,
  input wire logic [DW-1:0] rom_wi_in,
  input wire logic [DW-1:0] gen_cos_in,
  input wire logic [DW-1:0] gen_sin_in,
  // Memory strobes
  output logic rd_b_out,
  output logic rd_a_out,
  output logic wr_b_out,
  output logic wr_a_out,
  output logic [TAG_W-1:0] xfer_tag_out,
  output logic [AW-1:0] tw_addr_out,
  // Memory write data
  output logic [DW-1:0] mem_wr_re_out,
  output logic [DW-1:0] mem_wr_im_out,
  // Status
  output logic busy_out
);
  localparam int unsigned SLOTS = 3;

  // Per-butterfly context (three in flight)
  logic [STEP_W-1:0] step_q [SLOTS];
  logic [SLOTS-1:0] live_q;
  logic [AW-1:0] tw_q [SLOTS];
  logic tsrc_q [SLOTS];
  logic [DW-1:0] br_q [SLOTS];
  logic [DW-1:0] bi_q [SLOTS];
  logic [DW-1:0] ar_q [SLOTS];
  logic [DW-1:0] ai_q [SLOTS];
  logic [DW-1:0] p_rr_q [SLOTS];
  logic [DW-1:0] p_ri_q [SLOTS];
  logic [DW-1:0] p_ir_q [SLOTS];
  logic [DW-1:0] cre_q [SLOTS];
  logic [DW-1:0] cim_q [SLOTS];
  fbp_phase_type phase_q;
  logic [TAG_W-1:0] next_slot_q;

  // Shared multiplier signals
  logic [DW-1:0] multiplier_operand_port;
  logic [DW-1:0] tw_operand;
  logic [PROD_W-1:0] product;
  logic [DW-1:0] product_return_port;
  logic [TAG_W-1:0] mul_slot;
  logic mul_ok;
  logic mul_wi;
  logic [STEP_W-1:0] mul_step;

  // Phase counter gives the four-cycle initiation interval
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      phase_q <= FBP_PH_0;
    end else if (clk_en_in) begin
      unique case (phase_q)
        FBP_PH_0: phase_q <= FBP_PH_1;
        FBP_PH_1: phase_q <= FBP_PH_2;
        FBP_PH_2: phase_q <= FBP_PH_3;
        FBP_PH_3: phase_q <= FBP_PH_0;
      endcase
    end
  end

  // Launch and step every slot; a slot frees after the last step
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      live_q <= '0;
      next_slot_q <= SLOT_RESET;
      for (int i = 0; i < SLOTS; i++) begin
        step_q[i] <= '0;
        tw_q[i] <= '0;
        tsrc_q[i] <= 1'b0;
      end
    end else if (clk_en_in) begin
      for (int i = 0; i < SLOTS; i++) begin
        if (live_q[i]) begin
          if (step_q[i] == STEP_W'(SEQ_LEN - 1)) begin
            live_q[i] <= 1'b0;
          end else begin
            step_q[i] <= step_q[i] + 4'h1;
          end
        end
      end
      if (start_in && phase_q == FBP_PH_0) begin
        live_q[next_slot_q] <= 1'b1;
        step_q[next_slot_q] <= '0;
        tw_q[next_slot_q] <= tw_index_in;
        tsrc_q[next_slot_q] <= tw_src_in;
        next_slot_q <= (next_slot_q == TAG_W'(SLOTS - 1)) ? SLOT_RESET : next_slot_q + 2'h1;
      end
    end
  end

  // Find which slot is at a given step this cycle
  function automatic logic [TAG_W:0] find_slot(input logic [STEP_W-1:0] s,
                                               input logic [SLOTS-1:0] lv,
                                               input logic [STEP_W-1:0] st0,
                                               input logic [STEP_W-1:0] st1,
                                               input logic [STEP_W-1:0] st2);
    logic [TAG_W:0] r;
    r = '0;
    if (lv[0] && st0 == s) r = {1'b1, 2'h0};
    if (lv[1] && st1 == s) r = {1'b1, 2'h1};
    if (lv[2] && st2 == s) r = {1'b1, 2'h2};
    return r;
  endfunction : find_slot

  logic [TAG_W:0] f_rb, f_ra, f_wb, f_wa, f_m0, f_m1, f_m2, f_m3, f_cm;

  // Step lookup; the four-step overlay leaves one slot per step
  always_comb begin
    f_rb = find_slot(STEP_READ_B, live_q, step_q[0], step_q[1], step_q[2]);
    f_ra = find_slot(STEP_READ_A, live_q, step_q[0], step_q[1], step_q[2]);
    f_wb = find_slot(STEP_WRITE_B, live_q, step_q[0], step_q[1], step_q[2]);
    f_wa = find_slot(STEP_WRITE_A, live_q, step_q[0], step_q[1], step_q[2]);
    f_m0 = find_slot(STEP_MUL_RR, live_q, step_q[0], step_q[1], step_q[2]);
    f_m1 = find_slot(STEP_MUL_RI, live_q, step_q[0], step_q[1], step_q[2]);
    f_m2 = find_slot(STEP_MUL_IR, live_q, step_q[0], step_q[1], step_q[2]);
    f_m3 = find_slot(STEP_MUL_II, live_q, step_q[0], step_q[1], step_q[2]);
    f_cm = find_slot(STEP_COMMON, live_q, step_q[0], step_q[1], step_q[2]);
  end

  // Multiplier issue: one operand pair per cycle
  always_comb begin
    mul_ok = 1'b1;
    mul_wi = 1'b0;
    mul_step = STEP_MUL_RR;
    mul_slot = f_m0[TAG_W-1:0];
    if (f_m0[TAG_W]) begin
      mul_step = STEP_MUL_RR;
    end else if (f_m1[TAG_W]) begin
      mul_step = STEP_MUL_RI;
      mul_slot = f_m1[TAG_W-1:0];
      mul_wi = 1'b1;
    end else if (f_m2[TAG_W]) begin
      mul_step = STEP_MUL_IR;
      mul_slot = f_m2[TAG_W-1:0];
    end else if (f_m3[TAG_W]) begin
      mul_step = STEP_MUL_II;
      mul_slot = f_m3[TAG_W-1:0];
      mul_wi = 1'b1;
    end else begin
      mul_ok = 1'b0;
    end
  end

  // Operand port carries Br for the first two products, Bi after
  assign multiplier_operand_port = (mul_step == STEP_MUL_RR || mul_step == STEP_MUL_RI) ?
                                   br_q[mul_slot] : bi_q[mul_slot];
  // Twiddle side from ROM or sine/cosine generator
  assign tw_operand = (tsrc_q[mul_slot] == FBP_TW_GEN) ?
                      (mul_wi ? gen_sin_in : gen_cos_in) :
                      (mul_wi ? rom_wi_in : rom_wr_in);
  // Sign-extend both sides so the product is never cut at operand width
  logic signed [PROD_W-1:0] mul_x, mul_y;
  assign mul_x = {{(PROD_W - DW){multiplier_operand_port[DW-1]}}, multiplier_operand_port};
  assign mul_y = {{(PROD_W - DW){tw_operand[DW-1]}}, tw_operand};
  assign product = mul_x * mul_y;
  assign product_return_port = product[PROD_W-1:DW];
  assign tw_addr_out = tw_q[mul_slot];

  // Slice-based processors, real and imaginary
  logic [DW-1:0] re_sum, im_sum, re_x, re_y, im_x, im_y;
  logic re_sub, im_sub;
  logic [DW/SLICE_W:0] re_c, im_c;

  // ALU operand selection per step
  always_comb begin
    re_x = p_rr_q[mul_slot];
    re_y = product_return_port;
    re_sub = 1'b1; // BrWr - BiWi
    im_x = p_ir_q[f_cm[TAG_W-1:0]]; // Common-step slot, not the one multiplying
    im_y = p_ri_q[f_cm[TAG_W-1:0]];
    im_sub = 1'b0; // BiWr + BrWi
  end

  assign re_c[0] = re_sub;
  assign im_c[0] = im_sub;

  // Two cascaded 8-bit slices per processor
  for (genvar g = 0; g < DW / SLICE_W; g++) begin : g_slice
    fbp_slice_alu #(.W(SLICE_W)) u_re (
      .a_in(re_x[g*SLICE_W +: SLICE_W]),
      .b_in(re_y[g*SLICE_W +: SLICE_W]),
      .sub_in(re_sub),
      .carry_in(re_c[g]),
      .sum_out(re_sum[g*SLICE_W +: SLICE_W]),
      .carry_out(re_c[g+1])
    );
    fbp_slice_alu #(.W(SLICE_W)) u_im (
      .a_in(im_x[g*SLICE_W +: SLICE_W]),
      .b_in(im_y[g*SLICE_W +: SLICE_W]),
      .sub_in(im_sub),
      .carry_in(im_c[g]),
      .sum_out(im_sum[g*SLICE_W +: SLICE_W]),
      .carry_out(im_c[g+1])
    );
  end

  // Final add/subtract on 16 bits
  logic [DW-1:0] ar_sel, ai_sel, cr_sel, ci_sel;
  assign ar_sel = ar_q[f_wb[TAG_W-1:0]];
  assign ai_sel = ai_q[f_wb[TAG_W-1:0]];
  assign cr_sel = cre_q[f_wb[TAG_W-1:0]];
  assign ci_sel = cim_q[f_wb[TAG_W-1:0]];

  // Operand capture and product registers per slot
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      for (int i = 0; i < SLOTS; i++) begin
        br_q[i] <= '0;
        bi_q[i] <= '0;
        ar_q[i] <= '0;
        ai_q[i] <= '0;
        p_rr_q[i] <= '0;
        p_ri_q[i] <= '0;
        p_ir_q[i] <= '0;
        cre_q[i] <= '0;
        cim_q[i] <= '0;
      end
    end else if (clk_en_in) begin
      if (f_rb[TAG_W]) begin
        br_q[f_rb[TAG_W-1:0]] <= mem_rd_re_in;
        bi_q[f_rb[TAG_W-1:0]] <= mem_rd_im_in;
      end
      if (f_ra[TAG_W]) begin
        ar_q[f_ra[TAG_W-1:0]] <= mem_rd_re_in;
        ai_q[f_ra[TAG_W-1:0]] <= mem_rd_im_in;
      end
      // Four products per butterfly
      if (mul_ok && mul_step == STEP_MUL_RR) p_rr_q[mul_slot] <= product_return_port;
      if (mul_ok && mul_step == STEP_MUL_RI) p_ri_q[mul_slot] <= product_return_port;
      if (mul_ok && mul_step == STEP_MUL_IR) p_ir_q[mul_slot] <= product_return_port;
      if (mul_ok && mul_step == STEP_MUL_II) begin
        cre_q[mul_slot] <= re_sum; // One subtract, stored once
      end
      if (f_cm[TAG_W]) begin
        cim_q[f_cm[TAG_W-1:0]] <= im_sum; // One add, stored once
      end
    end
  end

  // Result writes: B' then A', tagged with their butterfly
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wr_b_out <= 1'b0;
      wr_a_out <= 1'b0;
      xfer_tag_out <= '0;
      mem_wr_re_out <= '0;
      mem_wr_im_out <= '0;
    end else if (clk_en_in) begin
      wr_b_out <= 1'b0;
      wr_a_out <= 1'b0;
      if (f_wb[TAG_W]) begin
        wr_b_out <= 1'b1;
        xfer_tag_out <= f_wb[TAG_W-1:0];
        mem_wr_re_out <= ar_sel - cr_sel; // Br' = Ar - term
        mem_wr_im_out <= ai_sel - ci_sel; // Bi' = Ai - term
      end else if (f_wa[TAG_W]) begin
        wr_a_out <= 1'b1;
        xfer_tag_out <= f_wa[TAG_W-1:0];
        mem_wr_re_out <= ar_q[f_wa[TAG_W-1:0]] + cre_q[f_wa[TAG_W-1:0]];
        mem_wr_im_out <= ai_q[f_wa[TAG_W-1:0]] + cim_q[f_wa[TAG_W-1:0]];
      end
    end
  end

  // Read strobes are combinational, high on the read steps
  logic rd_b_now, rd_a_now;
  assign rd_b_now = f_rb[TAG_W];
  assign rd_a_now = f_ra[TAG_W];
  assign rd_b_out = rd_b_now;
  assign rd_a_out = rd_a_now;

  assign busy_out = |live_q;
endmodule : fbp_butterfly

/* File: fbp_far_model.sv */
// Far-side model: sample bus of the static RAM and twiddle tables
`timescale 1ns/100ps
module fbp_far_model (
  // Clock and bus requests
  input wire logic sys_clk_in,
  input wire logic pres_en_in,
  input wire logic [15:0] pres_re_in,
  input wire logic [15:0] pres_im_in,
  input wire logic [7:0] tw_addr_in,
  // Data to the block
  output logic [15:0] rd_re_out,
  output logic [15:0] rd_im_out,
  output logic [15:0] rom_wr_out,
  output logic [15:0] rom_wi_out,
  output logic [15:0] gen_cos_out,
  output logic [15:0] gen_sin_out
);
  logic [31:0] idle_q = 32'h0;
  // Released bus shows the inverse of its last value, toggling
  always @(posedge sys_clk_in) begin
    idle_q <= pres_en_in ? ~{pres_re_in, pres_im_in} : ~idle_q;
  end
  // Read data only valid while presented
  assign {rd_re_out, rd_im_out} = pres_en_in ? {pres_re_in, pres_im_in} : idle_q;
  // Table and generator contents by index
  assign rom_wr_out = {tw_addr_in, tw_addr_in ^ 8'h5a};
  assign rom_wi_out = {tw_addr_in ^ 8'hc3, tw_addr_in};
  assign gen_cos_out = {~tw_addr_in, tw_addr_in};
  assign gen_sin_out = {tw_addr_in, ~tw_addr_in};
endmodule : fbp_far_model

/* File: fbp_butterfly_sva.sv */
// Port checker for the butterfly pipeline
`timescale 1ns/100ps
module fbp_butterfly_sva
  import fbp_pkg::*;
#(
  parameter int unsigned DW = DATA_W,
  parameter int unsigned AW = TW_ADDR_W
) (
  // Clock, reset, control
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire logic clk_en_in,
  input wire logic start_in,
  input wire logic [AW-1:0] tw_index_in,
  input wire logic [DW-1:0] mem_rd_re_in,
  input wire logic [DW-1:0] mem_rd_im_in,
  // Watched outputs
  input wire logic rd_b_out,
  input wire logic rd_a_out,
  input wire logic wr_b_out,
  input wire logic wr_a_out,
  input wire logic [TAG_W-1:0] xfer_tag_out,
  input wire logic [AW-1:0] tw_addr_out,
  input wire logic [DW-1:0] mem_wr_re_out,
  input wire logic [DW-1:0] mem_wr_im_out,
  input wire logic busy_out
);
  logic [1:0] phase_q;
  logic [1:0] slot_q;
  logic launch;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);
  // Accepted start on beat zero
  assign launch = start_in && clk_en_in && phase_q == 2'h0;
  // Beat and slot counters
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      phase_q <= 2'h0;
      slot_q <= 2'h0;
    end else begin
      phase_q <= clk_en_in ? phase_q + 2'h1 : phase_q;
      slot_q <= launch ? (slot_q == 2'h2 ? 2'h0 : slot_q + 2'h1) : slot_q;
    end
  end
  a_read_b_step: assert property (launch |=> rd_b_out)
    else $error("B read strobe missing");
  a_read_a_step: assert property (launch |-> ##3 rd_a_out)
    else $error("A read strobe missing");
  a_b_write_time: assert property (launch |-> ##9 wr_b_out)
    else $error("B write late");
  a_a_write_time: assert property (launch |-> ##11 wr_a_out)
    else $error("A write late");
  a_b_write_cause: assert property (wr_b_out |-> $past(launch, 9))
    else $error("B write without launch");
  a_b_tag_slot: assert property (wr_b_out |-> xfer_tag_out == $past(slot_q, 9))
    else $error("B write tag wrong");
  a_a_tag_slot: assert property (wr_a_out |-> xfer_tag_out == $past(slot_q, 11))
    else $error("A write tag wrong");
  a_real_pair_sum: assert property (wr_a_out |->
    DW'(mem_wr_re_out + $past(mem_wr_re_out, 2)) == DW'($past(mem_rd_re_in, 8) << 1))
    else $error("real outputs not A plus and minus one term");
  a_imag_pair_sum: assert property (wr_a_out |->
    DW'(mem_wr_im_out + $past(mem_wr_im_out, 2)) == DW'($past(mem_rd_im_in, 8) << 1))
    else $error("imag outputs not A plus and minus one term");
  a_twiddle_addr: assert property (launch |->
    ##4 tw_addr_out == $past(tw_index_in, 4) ##1 $stable(tw_addr_out))
    else $error("twiddle index wrong");
  a_busy_live: assert property (launch |=> busy_out [*8])
    else $error("busy dropped");
endmodule : fbp_butterfly_sva
bind fbp_butterfly fbp_butterfly_sva #(.DW(DW), .AW(AW)) u_sva (
  .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .clk_en_in(clk_en_in),
  .start_in(start_in), .tw_index_in(tw_index_in), .mem_rd_re_in(mem_rd_re_in),
  .mem_rd_im_in(mem_rd_im_in), .rd_b_out(rd_b_out), .rd_a_out(rd_a_out),
  .wr_b_out(wr_b_out), .wr_a_out(wr_a_out),
  .xfer_tag_out(xfer_tag_out), .tw_addr_out(tw_addr_out),
  .mem_wr_re_out(mem_wr_re_out), .mem_wr_im_out(mem_wr_im_out), .busy_out(busy_out));

/* File: tb.sv */
// Self-checking bench for the butterfly pipeline
`timescale 1ns/100ps
module tb;
  import fbp_pkg::*;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic start = 1'b0;
  logic clk_en = 1'b1;
  logic rd_b, rd_a;
  logic src = 1'b0;
  logic pen = 1'b0;
  logic [7:0] idx = 8'h00;
  logic [15:0] pre = 16'h0000;
  logic [15:0] pim = 16'h0000;
  logic [15:0] rd_re, rd_im, rwr, rwi, gcos, gsin, wre, wim;
  logic [7:0] twa;
  logic [1:0] tag;
  logic wr_b, wr_a, busy;
  int miscompares = 0;
  int comparisons = 0;
  logic [15:0] br[8], bi[8], ar[8], ai[8];
  logic [7:0] vi[8];
  logic vs[8];
  // Clock of 100 ns
  initial forever #50 sys_clk = ~sys_clk;
  fbp_butterfly uut (
    .sys_clk_in(sys_clk), .reset_n_in(reset_n), .clk_en_in(clk_en),
    .start_in(start), .tw_src_in(src), .tw_index_in(idx),
    .mem_rd_re_in(rd_re), .mem_rd_im_in(rd_im), .rom_wr_in(rwr), .rom_wi_in(rwi),
    .gen_cos_in(gcos), .gen_sin_in(gsin), .rd_b_out(rd_b), .rd_a_out(rd_a),
    .wr_b_out(wr_b), .wr_a_out(wr_a), .xfer_tag_out(tag), .tw_addr_out(twa),
    .mem_wr_re_out(wre), .mem_wr_im_out(wim), .busy_out(busy));
  fbp_far_model far (
    .sys_clk_in(sys_clk), .pres_en_in(pen), .pres_re_in(pre), .pres_im_in(pim),
    .tw_addr_in(twa), .rd_re_out(rd_re), .rd_im_out(rd_im), .rom_wr_out(rwr),
    .rom_wi_out(rwi), .gen_cos_out(gcos), .gen_sin_out(gsin));
  // Upper half of a signed product
  function automatic logic [15:0] hi(logic [15:0] a, logic [15:0] b);
    logic signed [31:0] p;
    p = $signed(a) * $signed(b);
    return p[31:16];
  endfunction : hi
  // Twiddle pair expected from the far side
  function automatic logic [31:0] tw(logic [7:0] i, logic s);
    return s ? {~i, i, i, ~i} : {i, i ^ 8'h5a, i ^ 8'hc3, i};
  endfunction : tw
  task automatic chk_bit(string n, logic e, logic g);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s: expected %b seen %b", n, e, g);
    end
  endtask : chk_bit
  task automatic chk_word(string n, logic [15:0] e, logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask : chk_word
  task automatic check_out(int k, bit is_a);
    int j;
    logic [31:0] w;
    logic [15:0] cr, ci;
    j = k % 8;
    w = tw(vi[j], vs[j]);
    cr = hi(br[j], w[31:16]) - hi(bi[j], w[15:0]);
    ci = hi(bi[j], w[31:16]) + hi(br[j], w[15:0]);
    chk_word("re", is_a ? ar[j] + cr : ar[j] - cr, wre);
    chk_word("im", is_a ? ai[j] + ci : ai[j] - ci, wim);
    chk_word("tag", {14'h0, 2'(k % 3)}, {14'h0, tag});
  endtask : check_out
  task automatic do_reset;
    reset_n <= 1'b0;
    start <= 1'b0;
    repeat (4) @(posedge sys_clk);
    reset_n <= 1'b1;
  endtask : do_reset
  // Launches n butterflies four apart, a stray start, checks each cycle
  task automatic run_batch(int n, int stray);
    int j;
    bit eb, ea;
    for (int t = -1; t < 4 * n + 12; t++) begin
      j = ((t + 1) / 4) % 8;
      start <= ((t + 1) % 4 == 0 && (t + 1) / 4 < n) || t == stray;
      idx <= vi[j];
      src <= vs[j];
      pen <= t >= 0 && t % 2 == 0 && t < 4 * n;
      pre <= t % 4 == 0 ? br[j] : ar[j];
      pim <= t % 4 == 0 ? bi[j] : ai[j];
      #1;
      eb = t >= 8 && t % 4 == 0 && t < 4 * n + 8;
      ea = t >= 10 && t % 4 == 2 && t < 4 * n + 10;
      chk_bit("wr_b", eb, wr_b);
      chk_bit("wr_a", ea, wr_a);
      chk_bit("rd_b", t >= 0 && t % 4 == 0 && t < 4 * n, rd_b);
      chk_bit("rd_a", t >= 0 && t % 4 == 2 && t < 4 * n, rd_a);
      chk_bit("busy", t >= 0 && t < 4 * n + 6, busy);
      if (eb) check_out(t / 4 - 2, 1'b0);
      if (ea) check_out((t - 10) / 4, 1'b1);
      @(posedge sys_clk);
    end
    chk_bit("busy", 1'b0, busy);
  endtask : run_batch
  task automatic fill(logic [15:0] base);
    for (int i = 0; i < 8; i++) begin
      br[i] = base ^ 16'(i * 16'h1343);
      bi[i] = ~base + 16'(i * 16'h0bad);
      ar[i] = base + 16'h4000 - 16'(i * 16'h0777);
      ai[i] = ~br[i];
      vi[i] = base[7:0] + 8'(i * 8'h25);
      vs[i] = i[0];
    end
  endtask : fill
  // Full-scale negative Br operand, off-beat start refused
  task automatic sc_single_edge;
    do_reset();
    fill(16'h8000);
    run_batch(1, 5);
  endtask : sc_single_edge
  // Six back-to-back, both twiddle sources, slots wrap
  task automatic sc_stream;
    do_reset();
    fill(16'h1234);
    // Enable low for three edges must hold the launch beat
    clk_en <= 1'b0;
    repeat (3) @(posedge sys_clk);
    clk_en <= 1'b1;
    run_batch(6, 25);
  endtask : sc_stream
  task automatic final_report;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : final_report
  // Main sequence
  initial begin
    sc_single_edge();
    sc_stream();
    final_report();
  end
  // Watchdog
  initial begin
    repeat (2000) @(posedge sys_clk);
    miscompares++;
    final_report();
  end
endmodule : tb
